/* File: design/pcm_defines.svh */
`ifndef PCM_DEFINES_SVH
`define PCM_DEFINES_SVH

// ==========================================================
// Sizes
`define PCM_ADDR_W         8
`define PCM_DATA_W         8
`define PCM_PORT_COUNT     4
`define PCM_PIN_COUNT      32
`define PCM_FUNC_COUNT     16
`define PCM_PIN_IDX_W      5
`define PCM_FUNC_IDX_W     4
`define PCM_MATCH_PORT     3

// ==========================================================
// Register offsets
`define PCM_OFS_LATCH0     8'h80
`define PCM_OFS_LATCH_STEP 8'h10
`define PCM_OFS_OUTMODE0   8'hA4
`define PCM_OFS_ANALOG0    8'hF1
`define PCM_OFS_XBAR0      8'hE1
`define PCM_OFS_XBAR1      8'hE2
`define PCM_OFS_XBAR2      8'hE3
`define PCM_OFS_MATCH_VAL  8'hAE
`define PCM_OFS_MATCH_SEL  8'hAF
`define PCM_OFS_IRQ_STAT   8'hB8
`define PCM_OFS_IRQ_MASK   8'hB9

// ==========================================================
// Fields
`define PCM_XBAR_EN_BIT    6
`define PCM_IRQ_MISMATCH   0
`define PCM_IRQ_OVERFLOW   1
`define PCM_FUNC_IS_OUT    16'h7DF5

// ==========================================================
// Reset values
`define PCM_RST_LATCH      8'hFF
`define PCM_RST_OUTMODE    8'h00
`define PCM_RST_ANALOG     8'h00
`define PCM_RST_XBAR       8'h00
`define PCM_RST_MATCH_VAL  8'hFF
`define PCM_RST_MATCH_SEL  8'h00
`define PCM_RST_IRQ        8'h00

`endif

/* File: design/pcm_pkg.sv */
`include "pcm_defines.svh"

package pcm_pkg;

   // ==========================================================
   // Bus request
   typedef struct packed {
      logic [`PCM_ADDR_W-1:0] addr;
      logic [`PCM_DATA_W-1:0] wdata;
      logic                   wr;
      logic                   rd;
   } pcm_bus_req_t;

   // ==========================================================
   // Pin drive
   typedef struct packed {
      logic [`PCM_PIN_COUNT-1:0] out;
      logic [`PCM_PIN_COUNT-1:0] oe;
   } pcm_pin_drive_t;

   // ==========================================================
   // Crossbar placement result
   typedef struct packed {
      logic [`PCM_PIN_COUNT-1:0]                          used;
      logic [`PCM_PIN_COUNT-1:0][`PCM_FUNC_IDX_W-1:0]     funcOfPin;
      logic [`PCM_FUNC_COUNT-1:0][`PCM_PIN_IDX_W-1:0]     pinOfFunc;
      logic [`PCM_FUNC_COUNT-1:0]                         placed;
      logic                                               overflow;
   } pcm_route_t;

   // ==========================================================
   // Whole module state
   typedef struct packed {
      logic [`PCM_PORT_COUNT-1:0][`PCM_DATA_W-1:0] latch;
      logic [`PCM_PORT_COUNT-1:0][`PCM_DATA_W-1:0] outMode;
      logic [`PCM_PORT_COUNT-1:0][`PCM_DATA_W-1:0] analog;
      logic [2:0][`PCM_DATA_W-1:0]                 xbar;
      logic [`PCM_DATA_W-1:0]                      matchValue;
      logic [`PCM_DATA_W-1:0]                      matchSelect;
      logic [`PCM_DATA_W-1:0]                      irqStatus;
      logic [`PCM_DATA_W-1:0]                      irqMask;
      logic [`PCM_DATA_W-1:0]                      readData;
      pcm_pin_drive_t                              pins;
      logic [`PCM_FUNC_COUNT-1:0]                  funcIn;
   } pcm_state_t;

endpackage

/* File: design/pcm_port_crossbar_and_match.sv */
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`include "pcm_defines.svh"
// How it works
// - Reading a port latch returns live pin levels regardless of crossbar routing.
// - Enabled peripheral functions take pins in fixed priority order, lowest first.
// - Two crossbar select registers decide which functions the crossbar routes; bit 6 of the third enables it.
// - Each pin's output-mode bit picks push-pull or open-drain driving while the crossbar is enabled; with it off only the debug link can drive its pin.
// - Each pin acts as GPIO, peripheral pin, or analog function.
// - Highest pin is shared between GPIO and the debug link data line.
// - Unselected port-3 pins are ignored and never cause a mismatch.
// - Selected port-3 pins are compared with the same bit of the match value.
// - Match value bit 0 compares against low, bit 1 against high.
module pcm_port_crossbar_and_match
   import pcm_pkg::*;
(
   // Clock and reset
   input  wire logic                         sys_clk,
   input  wire logic                         reset,
   // Register port
   input  wire pcm_bus_req_t                 busReq,
   output      logic [`PCM_DATA_W-1:0]       busReadData,
   // Pins
   input  wire logic [`PCM_PIN_COUNT-1:0]    pinIn,
   output      logic [`PCM_PIN_COUNT-1:0]    pinOut,
   output      logic [`PCM_PIN_COUNT-1:0]    pinOe,
   // Peripheral side
   input  wire logic [`PCM_FUNC_COUNT-1:0]   funcOut,
   output      logic [`PCM_FUNC_COUNT-1:0]   funcIn,
   // Debug link data line
   input  wire logic                         debugActive,
   input  wire logic                         debugDataOut,
   input  wire logic                         debugDataOe,
   output      logic                         debugDataIn,
   // Interrupt
   output      logic                         irq
);

   localparam int PORTS = `PCM_PORT_COUNT;
   localparam int PINS  = `PCM_PIN_COUNT;
   localparam int FUNCS = `PCM_FUNC_COUNT;
   localparam int DEBUG_PIN = `PCM_PIN_COUNT - 1;
   // A bit-select cannot stand on a bare literal, so the direction mask gets a name
   localparam logic [`PCM_FUNC_COUNT-1:0] FUNC_IS_OUT = `PCM_FUNC_IS_OUT;

   pcm_state_t st;
   pcm_state_t next_st;

   // ==========================================================
   // Offset decoding
   function automatic logic [`PCM_ADDR_W-1:0] latchOffset(input int idx);
      latchOffset = `PCM_OFS_LATCH0 + 8'(idx) * `PCM_OFS_LATCH_STEP;
   endfunction

   function automatic logic [`PCM_ADDR_W-1:0] outModeOffset(input int idx);
      outModeOffset = `PCM_OFS_OUTMODE0 + 8'(idx);
   endfunction

   function automatic logic [`PCM_ADDR_W-1:0] analogOffset(input int idx);
      analogOffset = `PCM_OFS_ANALOG0 + 8'(idx);
   endfunction

   // ==========================================================
   // Priority placement: each enabled function, in index order, takes the
   // lowest free pin that is neither analog nor held by the debug link
   function automatic pcm_route_t crossbarRoute(
      input logic [FUNCS-1:0] enable,
      input logic [PINS-1:0]  skip
   );
      pcm_route_t r;
      logic [PINS-1:0] taken;
      logic            found;
      r        = '0;
      taken    = skip;
      for (int f = 0; f < FUNCS; f++) begin
         found = 1'b0;
         if (enable[f]) begin
            for (int p = 0; p < PINS; p++) begin
               if (!found && !taken[p]) begin
                  found              = 1'b1;
                  taken[p]           = 1'b1;
                  r.used[p]          = 1'b1;
                  r.funcOfPin[p]     = `PCM_FUNC_IDX_W'(f);
                  r.pinOfFunc[f]     = `PCM_PIN_IDX_W'(p);
                  r.placed[f]        = 1'b1;
               end
            end
            if (!found) begin
               r.overflow = 1'b1;
            end
         end
      end
      crossbarRoute = r;
   endfunction

   // ==========================================================
   // Combinational next state
   pcm_route_t                 route;
   logic [PINS-1:0]            analogFlat;
   logic [PINS-1:0]            outModeFlat;
   logic [PINS-1:0]            latchFlat;
   logic [PINS-1:0]            skipPins;
   logic [FUNCS-1:0]           funcEnable;
   logic                       xbarOn;
   logic                       mismatch;
   logic [`PCM_DATA_W-1:0]     port3Level;
   logic [`PCM_DATA_W-1:0]     readValue;
   logic [`PCM_DATA_W-1:0]     irqSet;
   logic [`PCM_DATA_W-1:0]     irqClear;
   logic                       driveVal;
   logic                       isPeriph;
   logic [`PCM_FUNC_IDX_W-1:0] fsel;

   always_comb begin
      next_st     = st;
      fsel        = '0;
      isPeriph    = 1'b0;
      driveVal    = 1'b0;
      analogFlat  = st.analog;
      outModeFlat = st.outMode;
      latchFlat   = st.latch;
      xbarOn      = st.xbar[2][`PCM_XBAR_EN_BIT];
      funcEnable  = {st.xbar[1], st.xbar[0]};
      // Analog pins are skipped; the debug pin is withheld while the link owns it
      skipPins    = analogFlat;
      skipPins[DEBUG_PIN] = skipPins[DEBUG_PIN] | debugActive;
      route       = crossbarRoute(xbarOn ? funcEnable : '0, skipPins);

      // Port match
      port3Level  = pinIn[`PCM_MATCH_PORT*`PCM_DATA_W +: `PCM_DATA_W];
      mismatch    = |((port3Level ^ st.matchValue) & st.matchSelect);

      // Register writes
      if (busReq.wr) begin
         for (int i = 0; i < PORTS; i++) begin
            if (busReq.addr == latchOffset(i)) begin
               next_st.latch[i] = busReq.wdata;
            end
            if (busReq.addr == outModeOffset(i)) begin
               next_st.outMode[i] = busReq.wdata;
            end
            if (busReq.addr == analogOffset(i)) begin
               next_st.analog[i] = busReq.wdata;
            end
         end
         case (busReq.addr)
            `PCM_OFS_XBAR0:     next_st.xbar[0]     = busReq.wdata;
            `PCM_OFS_XBAR1:     next_st.xbar[1]     = busReq.wdata;
            `PCM_OFS_XBAR2:     next_st.xbar[2]     = busReq.wdata;
            `PCM_OFS_MATCH_VAL: next_st.matchValue  = busReq.wdata;
            `PCM_OFS_MATCH_SEL: next_st.matchSelect = busReq.wdata;
            `PCM_OFS_IRQ_MASK:  next_st.irqMask     = busReq.wdata;
            default: ;
         endcase
      end

      // Register reads; a latch read shows the pins, not the stored value
      readValue = '0;
      for (int i = 0; i < PORTS; i++) begin
         if (busReq.addr == latchOffset(i)) begin
            readValue = pinIn[i*`PCM_DATA_W +: `PCM_DATA_W];
         end
         if (busReq.addr == outModeOffset(i)) begin
            readValue = st.outMode[i];
         end
         if (busReq.addr == analogOffset(i)) begin
            readValue = st.analog[i];
         end
      end
      case (busReq.addr)
         `PCM_OFS_XBAR0:     readValue = st.xbar[0];
         `PCM_OFS_XBAR1:     readValue = st.xbar[1];
         `PCM_OFS_XBAR2:     readValue = st.xbar[2];
         `PCM_OFS_MATCH_VAL: readValue = st.matchValue;
         `PCM_OFS_MATCH_SEL: readValue = st.matchSelect;
         `PCM_OFS_IRQ_STAT:  readValue = st.irqStatus;
         `PCM_OFS_IRQ_MASK:  readValue = st.irqMask;
         default: ;
      endcase
      next_st.readData = busReq.rd ? readValue : '0;

      // Sticky status: read clears, but an event in the same cycle survives
      irqSet   = '0;
      irqSet[`PCM_IRQ_MISMATCH] = mismatch;
      irqSet[`PCM_IRQ_OVERFLOW] = route.overflow;
      irqClear = (busReq.rd && busReq.addr == `PCM_OFS_IRQ_STAT) ? st.irqStatus : '0;
      next_st.irqStatus = (st.irqStatus & ~irqClear) | irqSet;

      // Pin drive
      for (int p = 0; p < PINS; p++) begin
         fsel     = route.funcOfPin[p];
         isPeriph = xbarOn && route.used[p];
         driveVal = isPeriph ? funcOut[fsel] : latchFlat[p];
         next_st.pins.out[p] = driveVal;
         if (analogFlat[p] || !xbarOn) begin
            // Analog pins and a disabled crossbar leave every output off except the debug pin while the link owns it
            next_st.pins.oe[p]  = 1'b0;
            next_st.pins.out[p] = 1'b0;
         end else if (isPeriph && !FUNC_IS_OUT[fsel]) begin
            next_st.pins.oe[p]  = 1'b0;
            next_st.pins.out[p] = 1'b0;
         end else begin
            // Open-drain only pulls low
            next_st.pins.oe[p] = outModeFlat[p] | ~driveVal;
            if (!outModeFlat[p]) begin
               next_st.pins.out[p] = 1'b0;
            end
         end
      end
      if (debugActive) begin
         next_st.pins.out[DEBUG_PIN] = debugDataOut;
         next_st.pins.oe[DEBUG_PIN]  = debugDataOe;
      end

      // Peripheral inputs idle high when their function has no pin
      for (int f = 0; f < FUNCS; f++) begin
         next_st.funcIn[f] = route.placed[f] ? pinIn[route.pinOfFunc[f]] : 1'b1;
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         st.latch       <= {PORTS{`PCM_RST_LATCH}};
         st.outMode     <= {PORTS{`PCM_RST_OUTMODE}};
         st.analog      <= {PORTS{`PCM_RST_ANALOG}};
         st.xbar        <= {3{`PCM_RST_XBAR}};
         st.matchValue  <= `PCM_RST_MATCH_VAL;
         st.matchSelect <= `PCM_RST_MATCH_SEL;
         st.irqStatus   <= `PCM_RST_IRQ;
         st.irqMask     <= `PCM_RST_IRQ;
         st.readData    <= '0;
         st.pins        <= '0;
         st.funcIn      <= '1;
      end else begin
         st <= next_st;
      end
   end

   // ==========================================================
   // Outputs
   assign busReadData = st.readData;
   assign pinOut      = st.pins.out;
   assign pinOe       = st.pins.oe;
   assign funcIn      = st.funcIn;
   assign debugDataIn = pinIn[DEBUG_PIN];
   assign irq         = |(st.irqStatus & st.irqMask);

endmodule

/* File: verification/pcm_match_properties.sv */
`timescale 1ns/1ps
module pcm_match_checker
   import pcm_pkg::*;
(
   input wire logic         sys_clk,
   input wire logic         reset,
   input wire pcm_bus_req_t busReq,
   input wire logic [7:0]   busReadData,
   input wire logic [31:0]  pinIn,
   input wire logic [31:0]  pinOe,
   input wire logic         debugActive,
   input wire logic         debugDataIn,
   input wire logic         irq
);
   logic [7:0] mVal;
   logic [7:0] mSel;
   logic [7:0] mMask;
   logic [7:0] xSel2;
   logic [7:0] port0;
   logic       mm;

   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);

   // ==========
   // Shadows of the registers that steer the checks
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         mVal <= 8'hFF;
         mSel <= 8'h00;
         mMask <= 8'h00;
         xSel2 <= 8'h00;
      end else if (busReq.wr) begin
         if (busReq.addr == 8'hAE) mVal <= busReq.wdata;
         if (busReq.addr == 8'hAF) mSel <= busReq.wdata;
         if (busReq.addr == 8'hB9) mMask <= busReq.wdata;
         if (busReq.addr == 8'hE3) xSel2 <= busReq.wdata;
      end
   end
   assign port0 = pinIn[7:0];
   assign mm = |((pinIn[31:24] ^ mVal) & mSel);

   sequence s_rd(a);
      busReq.rd && busReq.addr == a;
   endsequence
   // Mask fixed to the mismatch bit so overflow cannot interfere
   sequence s_mism;
      mm && mMask == 8'h01 && !busReq.wr;
   endsequence
   sequence s_clr;
      s_rd(8'hB8) ##0 (!mm && mMask == 8'h01);
   endsequence

   // ==========
   // Assertions
   a_read_idle: assert property (!$past(busReq.rd) |-> busReadData == 8'h00)
      else $error("read data outside its slot");
   a_live_read: assert property (s_rd(8'h80) |=> busReadData == $past(port0))
      else $error("latch read not live pin level");
   a_sel_readback: assert property (s_rd(8'hAF) |=> busReadData == $past(mSel))
      else $error("match select readback wrong");
   a_debug_copy: assert property (debugDataIn == pinIn[31])
      else $error("debug data line not pin level");
   a_xbar_off: assert property ((!xSel2[6] && !debugActive) [*2] |-> pinOe == 32'h0)
      else $error("pin driven with crossbar off");
   a_mism_irq: assert property (s_mism |=> irq)
      else $error("mismatch gave no interrupt");
   a_irq_cause: assert property ($rose(irq) && mMask == 8'h01 && !$past(busReq.wr) |-> $past(mm))
      else $error("interrupt without mismatch");
   a_irq_clear: assert property (s_clr |=> !irq)
      else $error("status read did not clear");
endmodule

bind pcm_port_crossbar_and_match pcm_match_checker u_pcm_match_checker (
   .sys_clk(sys_clk), .reset(reset), .busReq(busReq), .busReadData(busReadData), .pinIn(pinIn),
   .pinOe(pinOe), .debugActive(debugActive), .debugDataIn(debugDataIn), .irq(irq));

/* File: verification/pcm_pin_partner.sv */
`timescale 1ns/1ps
// ==========
// Pin wiring: a pin nobody drives floats up to its pull-up
module pcm_pin_partner (
   input  wire logic [31:0] pinOut,
   input  wire logic [31:0] pinOe,
   input  wire logic [31:0] extOe,
   input  wire logic [31:0] extVal,
   output      logic [31:0] pinIn
);
   always_comb begin
      for (int i = 0; i < 32; i++) begin
         pinIn[i] = pinOe[i] ? pinOut[i] : (extOe[i] ? extVal[i] : 1'b1);
      end
   end
endmodule

/* File: verification/pcm_port_crossbar_and_match_bench.sv */
`timescale 1ns/1ps
module pcm_port_crossbar_and_match_bench
   import pcm_pkg::*;
();
   typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} pcm_row_t;
   logic         sys_clk;
   logic         reset;
   logic         debugActive;
   logic         debugDataIn;
   logic         debugDataOut;
   logic         debugDataOe;
   logic         irq;
   pcm_bus_req_t busReq;
   logic [7:0]   busReadData;
   logic [31:0]  pinIn;
   logic [31:0]  pinOut;
   logic [31:0]  pinOe;
   logic [31:0]  extOe;
   logic [31:0]  extVal;
   logic [15:0]  funcOut;
   logic [15:0]  funcIn;
   int           failures;
   int           n_tests;
   // Last row hits an unmapped place: write ignored, read gives 0
   pcm_row_t     rows [7] = '{'{8'hAE, 8'h3C, 8'h3C}, '{8'hAF, 8'hA5, 8'hA5}, '{8'hB9, 8'h03, 8'h03},
                              '{8'hE3, 8'h40, 8'h40}, '{8'hA4, 8'hFF, 8'hFF}, '{8'hF1, 8'h0F, 8'h0F},
                              '{8'h3F, 8'h77, 8'h00}};

   pcm_port_crossbar_and_match u_pcm_port_crossbar_and_match (
      .sys_clk(sys_clk), .reset(reset), .busReq(busReq), .busReadData(busReadData), .pinIn(pinIn),
      .pinOut(pinOut), .pinOe(pinOe), .funcOut(funcOut), .funcIn(funcIn), .debugActive(debugActive),
      .debugDataOut(debugDataOut), .debugDataOe(debugDataOe), .debugDataIn(debugDataIn), .irq(irq));
   pcm_pin_partner u_pcm_pin_partner (
      .pinOut(pinOut), .pinOe(pinOe), .extOe(extOe), .extVal(extVal), .pinIn(pinIn));

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   // ==========
   // Bus and pin tasks, each starts at a rising edge
   task automatic check(input logic [63:0] seen, input logic [63:0] want);
      n_tests++;
      if (seen !== want) begin
         failures++;
         $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      busReq.wr <= 1'b0;
      @(posedge sys_clk);
      #1;
   endtask
   task automatic rdck(input logic [7:0] a, input logic [7:0] want);
      @(posedge sys_clk);
      busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk);
      busReq.rd <= 1'b0;
      #1;
      check(busReadData, want);
   endtask
   task automatic apply(input logic [31:0] o, input logic [31:0] v, input logic [15:0] f);
      @(posedge sys_clk);
      extOe <= o;
      extVal <= v;
      funcOut <= f;
      @(posedge sys_clk);
      #1;
   endtask
   task automatic rst();
      @(posedge sys_clk);
      reset <= 1'b1;
      repeat (6) @(posedge sys_clk);
      reset <= 1'b0;
   endtask
   task automatic complete_run();
      $display("failures=%0d n_tests=%0d", failures, n_tests);
      if (failures == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge sys_clk);
      failures++;
      complete_run();
   end

   // ==========
   // Main sequence
   initial begin
      {busReq, extOe, extVal, funcOut, debugActive, debugDataOut, debugDataOe, failures, n_tests} = '0;
      reset = 1'b1;
      rst();
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rdck(rows[i].a, rows[i].e);
      end
      rst();
      rdck(8'hAE, 8'hFF);
      rdck(8'hAF, 8'h00);
      check({irq, pinOe, funcIn}, {33'h0, 16'hFFFF});
      apply(32'hFF, 32'hA5, 16'h0);
      rdck(8'h80, 8'hA5);
      apply(32'h0, 32'h0, 16'h0);
      wr(8'hE3, 8'h40);
      wr(8'hA4, 8'hFF);
      wr(8'h80, 8'h00);
      check({pinOe[7:0], pinOut[7:0]}, 16'hFF00);
      wr(8'hA4, 8'h00);
      wr(8'h80, 8'h0F);
      check({pinOe[7:0], pinOut[7:0]}, 16'hF000);
      rdck(8'h80, 8'h0F);
      wr(8'h80, 8'h00);
      wr(8'hF1, 8'h01);
      check(pinOe[7:0], 8'hFE);
      wr(8'hF1, 8'h00);
      wr(8'hA4, 8'hFF);
      wr(8'h80, 8'hFF);
      wr(8'hE1, 8'h07);
      apply(32'h2, 32'h0, 16'h0004);
      check({pinOe[2:0], pinOut[2], pinOut[0], funcIn[1]}, 6'b101100);
      for (int b = 0; b < 2; b++) begin
         apply(32'h80000000, b << 31, 16'h0004);
         check(debugDataIn, b[0]);
      end
      // Debug link takes the top pin and pulls it low
      @(posedge sys_clk);
      debugActive <= 1'b1;
      debugDataOe <= 1'b1;
      debugDataOut <= 1'b0;
      apply(32'h0, 32'h0, 16'h0004);
      check({pinOe[31], pinOut[31], debugDataIn}, 3'b100);
      @(posedge sys_clk);
      debugActive <= 1'b0;
      debugDataOe <= 1'b0;
      wr(8'hB9, 8'h01);
      wr(8'hAE, 8'h00);
      wr(8'hAF, 8'h01);
      check(irq, 1'b1);
      rdck(8'hB8, 8'h01);
      check(irq, 1'b1);
      wr(8'hB9, 8'h00);
      check(irq, 1'b0);
      wr(8'hB9, 8'h01);
      check(irq, 1'b1);
      apply(32'h01000000, 32'h0, 16'h0004);
      rdck(8'hB8, 8'h01);
      check(irq, 1'b0);
      wr(8'hAE, 8'h01);
      check(irq, 1'b1);
      wr(8'hAF, 8'h00);
      rdck(8'hB8, 8'h01);
      apply(32'h01000000, 32'h0, 16'h0004);
      check(irq, 1'b0);
      complete_run();
   end
endmodule
